// file: testbench/gpin_pin_model.sv
// Pin-side model of one port: drives the pins or leaves them to the pulls
`timescale 1ns/1ps
module gpin_pin_model #(
  parameter W = 8
) (
  // Clock
  input  wire         clock_in,
  // Bench drive request
  input  wire         drive_in,
  input  wire [W-1:0] level_in,
  // Pull controls from the block
  input  wire [W-1:0] pull_en_in,
  input  wire [W-1:0] pull_down_in,
  // Pin levels
  output reg  [W-1:0] pin_out
);
  reg [W-1:0] float_reg = {W{1'b0}};
  // A bare undriven pin wanders
  always @(posedge clock_in) begin
    float_reg <= ~float_reg;
  end
  always @* begin
    pin_out = drive_in ? level_in : ((pull_en_in & ~pull_down_in) | (~pull_en_in & float_reg));
  end
endmodule // gpin_pin_model

// file: testbench/gpin_port_props.sv
// Assertion checker for the port input block
`timescale 1ns/1ps
module gpin_port_props (
  input wire        clock_in,
  input wire        rst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0]  pstrb_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire [7:0]  p0_pull_en_out,
  input wire [7:0]  p0_pull_down_out,
  input wire [7:0]  p1_pull_en_out,
  input wire [7:0]  p1_pull_down_out,
  input wire [4:0]  p2_pull_en_out,
  input wire [4:0]  p2_pull_down_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire rd_ok = psel_in && pready_out && !pwrite_in;
  wire wr_ok = psel_in && pready_out && pwrite_in && pstrb_in[0];
  wire [7:0] dn0 = p0_pull_down_out & p0_pull_en_out;
  wire [7:0] dn1 = p1_pull_down_out & p1_pull_en_out;
  wire [4:0] dn2 = p2_pull_down_out & p2_pull_en_out;
  AST_P1_NO_PULL: assert property (p1_pull_en_out[1:0] == 2'h0 && p1_pull_down_out[1:0] == 2'h0)
    else $error("port 1 low pins pulled");
  AST_P0_ONE_POL: assert property (dn0 == 8'h00 || dn0 == p0_pull_en_out)
    else $error("port 0 mixed pull polarity");
  AST_P1_ONE_POL: assert property (dn1 == 8'h00 || dn1 == p1_pull_en_out)
    else $error("port 1 mixed pull polarity");
  AST_P2_ONE_POL: assert property (dn2 == 5'h00 || dn2 == p2_pull_en_out)
    else $error("port 2 mixed pull polarity");
  AST_P2_FLAG_TOP: assert property (rd_ok && paddr_in == 12'h22C |-> prdata_out[7:5] == 3'h0)
    else $error("port 2 flag top bits set");
  AST_P1_MODE_LOW: assert property (rd_ok && paddr_in == 12'h3D8 |-> prdata_out[1:0] == 2'h0)
    else $error("port 1 mode low bits set");
  AST_READY_TIME: assert property (psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
    else $error("access answer late or early");
  AST_P2_MODE_WR: assert property (wr_ok && paddr_in == 12'h3DC |->
    ##2 (p2_pull_en_out == ~$past(pwdata_in[4:0], 2)))
    else $error("port 2 pull enables wrong");
  AST_P1_MODE_WR: assert property (wr_ok && paddr_in == 12'h3D8 |->
    ##2 (p1_pull_en_out[7:2] == ~$past(pwdata_in[7:2], 2)))
    else $error("port 1 pull enables wrong");
endmodule // gpin_port_props
bind gpin_port_top gpin_port_props u_props (.*);

// file: testbench/test_gpin_port_top.sv
// Self-checking bench for the port input block
`timescale 1ns/1ps
`include "gpin_regs.vh"
module test_gpin_port_top;
  reg         clock_in = 1'b0;
  reg         rst_in = 1'b1;
  reg         psel_in = 1'b0;
  reg         penable_in = 1'b0;
  reg         pwrite_in = 1'b0;
  reg  [11:0] paddr_in = 12'h000;
  reg  [31:0] pwdata_in = 32'h00000000;
  reg  [3:0]  pstrb_in = 4'hF;
  reg         drive = 1'b1;
  reg  [7:0]  lvl [0:2] = '{8'h00, 8'h00, 8'h00};
  wire [31:0] prdata_out;
  wire        pready_out, pslverr_out, irq_out;
  wire [7:0]  p0_pin, p1_pin, p0_pen, p0_pdn, p1_pen, p1_pdn;
  wire [4:0]  p2_pin, p2_pen, p2_pdn;
  int         fail_count = 0;
  int         checked = 0;
  int         cycles = 0;
  logic [7:0] rd, m0, m1, m2, pat, keep, pend;
  logic       er;
  gpin_port_top dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .p0_pin_in(p0_pin),
    .p1_pin_in(p1_pin), .p2_pin_in(p2_pin), .usb_suspended_in(1'b0), .usb_resume_in(1'b0),
    .p0_pull_en_out(p0_pen), .p0_pull_down_out(p0_pdn), .p1_pull_en_out(p1_pen),
    .p1_pull_down_out(p1_pdn), .p2_pull_en_out(p2_pen), .p2_pull_down_out(p2_pdn),
    .irq_out(irq_out));
  gpin_pin_model #(.W(8)) pins0 (.clock_in(clock_in), .drive_in(drive), .level_in(lvl[0]),
    .pull_en_in(p0_pen), .pull_down_in(p0_pdn), .pin_out(p0_pin));
  gpin_pin_model #(.W(8)) pins1 (.clock_in(clock_in), .drive_in(drive), .level_in(lvl[1]),
    .pull_en_in(p1_pen), .pull_down_in(p1_pdn), .pin_out(p1_pin));
  gpin_pin_model #(.W(5)) pins2 (.clock_in(clock_in), .drive_in(drive), .level_in(lvl[2][4:0]),
    .pull_en_in(p2_pen), .pull_down_in(p2_pdn), .pin_out(p2_pin));
  always #25 clock_in = ~clock_in;
  function automatic [11:0] ad(input [7:0] i);
    ad = {2'h0, i, 2'h0};
  endfunction
  function automatic [7:0] fmask(input int p);
    fmask = (p == 2) ? `GPIN_MASK_P2_PEND : 8'hFF;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out[7:0];
    er = pslverr_out;
    if (n >= 20) fail_count++;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'hE7A4B93D));
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(0, ad(`GPIN_IDX_P0_PEND + i), 8'h00);
      check("flags at reset", rd, 8'h00);
    end
    apb(0, ad(8'h00), 8'h00);
    check("unmapped error", {7'h00, er}, 8'h01);
    apb(0, 12'h225, 8'h00);
    check("misaligned error", {7'h00, er}, 8'h01);
    repeat (8) begin
      m0 = $urandom;
      m1 = $urandom;
      m2 = $urandom;
      apb(1, ad(`GPIN_IDX_P0_MODE), m0);
      apb(1, ad(`GPIN_IDX_P1_MODE), m1);
      apb(1, ad(`GPIN_IDX_P2_MODE), m2);
      apb(0, ad(`GPIN_IDX_P1_MODE), 8'h00);
      check("p1 mode", rd, m1 & `GPIN_MASK_P1_MODE);
      apb(0, ad(`GPIN_IDX_P2_MODE), 8'h00);
      check("p2 mode", rd, m2);
      check("p1 pull en", p1_pen, ~m1 & 8'hFC);
      check("p1 pull dn", p1_pdn & p1_pen, {8{m2[6]}} & ~m1 & 8'hFC);
      check("p2 pull en", {3'h0, p2_pen}, {3'h0, ~m2[4:0]});
      check("p2 pull dn", {3'h0, p2_pdn & p2_pen}, {3'h0, {5{m2[7]}} & ~m2[4:0]});
      check("p0 pull dn", p0_pdn & p0_pen, {8{m2[5]}} & ~m0);
      check("p0 pull en", p0_pen, ~m0);
    end
    apb(1, ad(`GPIN_IDX_IRQ_MASK), 8'h07);
    for (int p = 0; p < 3; p++) begin
      for (int f = 0; f < 2; f++) begin
        pat = $urandom | 8'h01;
        pend = `GPIN_IDX_P0_PEND + p;
        apb(1, ad(`GPIN_IDX_EDGE_POL), f ? 8'h07 : 8'h00);
        for (int q = 0; q < 3; q++) lvl[q] <= f ? 8'hFF : 8'h00;
        repeat (8) @(posedge clock_in);
        apb(1, ad(pend), 8'h00);
        apb(1, ad(`GPIN_IDX_IRQ_STAT), 8'h07);
        lvl[p] <= (f ? 8'hFF : 8'h00) ^ pat;
        repeat (8) @(posedge clock_in);
        apb(0, ad(pend), 8'h00);
        check("flags", rd, pat & fmask(p));
        check("irq raised", {7'h00, irq_out}, 8'h01);
        apb(1, ad(`GPIN_IDX_IRQ_MASK), 8'h00);
        repeat (2) @(posedge clock_in);
        check("irq masked", {7'h00, irq_out}, 8'h00);
        apb(1, ad(`GPIN_IDX_IRQ_MASK), 8'h07);
        keep = $urandom;
        apb(1, ad(pend), keep);
        apb(0, ad(pend), 8'h00);
        check("flags kept", rd, pat & keep & fmask(p));
      end
    end
    apb(1, ad(`GPIN_IDX_EDGE_POL), 8'h00);
    apb(1, ad(`GPIN_IDX_P2_MODE), 8'h00);
    for (int q = 0; q < 3; q++) lvl[q] <= 8'h00;
    repeat (8) @(posedge clock_in);
    apb(1, ad(`GPIN_IDX_P2_PEND), 8'h00);
    drive <= 1'b0;
    repeat (8) @(posedge clock_in);
    apb(0, ad(`GPIN_IDX_P2_PEND), 8'h00);
    check("pulled up flags", rd, 8'h1F);
    complete_run();
  end
endmodule // test_gpin_port_top

// file: verilog/gpin_port_top.v
// Port input mode, pull control and pin interrupt flags with APB register access
`timescale 1ns/1ps
`include "gpin_regs.vh"
module gpin_port_top #(
  parameter USB_VARIANT = 0
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // Pins
  input  wire [7:0]  p0_pin_in,
  input  wire [7:0]  p1_pin_in,
  input  wire [4:0]  p2_pin_in,
  // USB resume event from the USB core, same clock
  input  wire        usb_suspended_in,
  input  wire        usb_resume_in,
  // Pull controls per pin
  output reg  [7:0]  p0_pull_en_out,
  output reg  [7:0]  p0_pull_down_out,
  output reg  [7:0]  p1_pull_en_out,
  output reg  [7:0]  p1_pull_down_out,
  output reg  [4:0]  p2_pull_en_out,
  output reg  [4:0]  p2_pull_down_out,
  // Interrupt
  output reg         irq_out
);
  // Registers
  reg  [7:0] p0_mode_reg;
  reg  [7:0] port1_input_mode_reg;
  reg  [7:0] port2_input_mode_pull_sel_reg;
  reg  [7:0] port0_irq_pending_reg;
  reg  [7:0] port1_irq_pending_reg;
  reg  [7:0] port2_irq_pending_reg;
  reg  [7:0] edge_pol_reg;
  reg  [7:0] irq_mask_reg;
  reg  [7:0] irq_stat_reg;
  reg  [7:0] p0_prev_reg;
  reg  [7:0] p1_prev_reg;
  reg  [4:0] p2_prev_reg;

  reg  [7:0] port0_irq_pending_next;
  reg  [7:0] port1_irq_pending_next;
  reg  [7:0] port2_irq_pending_next;
  reg  [7:0] irq_stat_next;
  reg  [7:0] rd_byte;
  reg        addr_ok;

  wire [7:0] p0_lvl;
  wire [7:0] p1_lvl;
  wire [4:0] p2_lvl;

  gpin_sync #(.WIDTH(8)) u_sync_p0 (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .pin_in    (p0_pin_in),
    .level_out (p0_lvl)
  );
  gpin_sync #(.WIDTH(8)) u_sync_p1 (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .pin_in    (p1_pin_in),
    .level_out (p1_lvl)
  );
  gpin_sync #(.WIDTH(5)) u_sync_p2 (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .pin_in    (p2_pin_in),
    .level_out (p2_lvl)
  );

  // Bus decode
  wire       acc      = psel_in & penable_in & pready_out;
  wire       wr_acc   = acc & pwrite_in & pstrb_in[0] & (paddr_in[11:10] == 2'b00);
  wire       aligned  = (paddr_in[1:0] == 2'b00);
  wire [7:0] idx      = paddr_in[9:2];
  wire [7:0] wbyte    = pwdata_in[7:0];
  wire       wr_p0f   = wr_acc & aligned & (idx == `GPIN_IDX_P0_PEND);
  wire       wr_p1f   = wr_acc & aligned & (idx == `GPIN_IDX_P1_PEND);
  wire       wr_p2f   = wr_acc & aligned & (idx == `GPIN_IDX_P2_PEND);
  wire       wr_stat  = wr_acc & aligned & (idx == `GPIN_IDX_IRQ_STAT);

  // Edge detection with per-port polarity
  wire       p0_fall  = edge_pol_reg[`GPIN_BIT_P0_EDGE];
  wire       p1_fall  = edge_pol_reg[`GPIN_BIT_P1_EDGE];
  wire       p2_fall  = edge_pol_reg[`GPIN_BIT_P2_EDGE];
  wire [7:0] p0_edge  = p0_fall ? (p0_prev_reg & ~p0_lvl) : (~p0_prev_reg & p0_lvl);
  wire [7:0] p1_edge  = p1_fall ? (p1_prev_reg & ~p1_lvl) : (~p1_prev_reg & p1_lvl);
  wire [4:0] p2_edge  = p2_fall ? (p2_prev_reg & ~p2_lvl) : (~p2_prev_reg & p2_lvl);

  // Resume only counts while suspended; it acts as an edge on bit 7 under either port 0 polarity
  wire       resume_evt = usb_resume_in & usb_suspended_in;
  wire [7:0] p0_set     = (USB_VARIANT != 0) ?
                          {resume_evt, 1'b0, p0_edge[5:0]} : p0_edge;

  // Flag update: writing 0 clears, writing 1 keeps, a new event wins
  always @* begin
    port0_irq_pending_next = port0_irq_pending_reg;
    port1_irq_pending_next = port1_irq_pending_reg;
    port2_irq_pending_next = port2_irq_pending_reg;
    if (wr_p0f) begin
      port0_irq_pending_next = port0_irq_pending_reg & wbyte;
    end
    if (wr_p1f) begin
      port1_irq_pending_next = port1_irq_pending_reg & wbyte;
    end
    if (wr_p2f) begin
      port2_irq_pending_next = port2_irq_pending_reg & wbyte;
    end
    port0_irq_pending_next = port0_irq_pending_next | p0_set;
    port1_irq_pending_next = port1_irq_pending_next | p1_edge;
    port2_irq_pending_next = (port2_irq_pending_next | {3'b000, p2_edge})
                             & `GPIN_MASK_P2_PEND;
    if (USB_VARIANT != 0) begin
      port0_irq_pending_next = port0_irq_pending_next & `GPIN_MASK_P0_USB;
    end
  end

  // Block status: one sticky bit per port, write one to clear, event wins
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_reg & ~wbyte;
    end
    irq_stat_next = (irq_stat_next | {5'b00000, (|p2_edge), (|p1_edge), (|p0_set)})
                    & `GPIN_MASK_IRQ;
  end

  // Read mux
  always @* begin
    addr_ok = aligned;
    rd_byte = `GPIN_RESET_BYTE;
    case (idx)
      `GPIN_IDX_P0_PEND:  rd_byte = port0_irq_pending_reg;
      `GPIN_IDX_P1_PEND:  rd_byte = port1_irq_pending_reg;
      `GPIN_IDX_P2_PEND:  rd_byte = port2_irq_pending_reg & `GPIN_MASK_P2_PEND;
      `GPIN_IDX_EDGE_POL: rd_byte = edge_pol_reg;
      `GPIN_IDX_P0_MODE:  rd_byte = p0_mode_reg;
      `GPIN_IDX_P1_MODE:  rd_byte = port1_input_mode_reg & `GPIN_MASK_P1_MODE;
      `GPIN_IDX_P2_MODE:  rd_byte = port2_input_mode_pull_sel_reg;
      `GPIN_IDX_IRQ_MASK: rd_byte = irq_mask_reg;
      `GPIN_IDX_IRQ_STAT: rd_byte = irq_stat_reg;
      default:            addr_ok = 1'b0;
    endcase
    if (paddr_in[11:10] != 2'b00) begin
      addr_ok = 1'b0;
    end
  end

  // Registers and bus answer
  always @(posedge clock_in) begin
    if (rst_in) begin
      p0_mode_reg                   <= `GPIN_RESET_BYTE;
      port1_input_mode_reg          <= `GPIN_RESET_BYTE;
      port2_input_mode_pull_sel_reg <= `GPIN_RESET_BYTE;
      port0_irq_pending_reg         <= `GPIN_RESET_BYTE;
      port1_irq_pending_reg         <= `GPIN_RESET_BYTE;
      port2_irq_pending_reg         <= `GPIN_RESET_BYTE;
      edge_pol_reg                  <= `GPIN_RESET_BYTE;
      irq_mask_reg                  <= `GPIN_RESET_BYTE;
      irq_stat_reg                  <= `GPIN_RESET_BYTE;
      p0_prev_reg                   <= 8'h00;
      p1_prev_reg                   <= 8'h00;
      p2_prev_reg                   <= 5'h00;
      prdata_out                    <= 32'h00000000;
      pready_out                    <= 1'b0;
      pslverr_out                   <= 1'b0;
    end else begin
      p0_prev_reg           <= p0_lvl;
      p1_prev_reg           <= p1_lvl;
      p2_prev_reg           <= p2_lvl;
      port0_irq_pending_reg <= port0_irq_pending_next;
      port1_irq_pending_reg <= port1_irq_pending_next;
      port2_irq_pending_reg <= port2_irq_pending_next;
      irq_stat_reg          <= irq_stat_next;
      if (wr_acc && addr_ok) begin
        case (idx)
          `GPIN_IDX_EDGE_POL: edge_pol_reg <= wbyte & `GPIN_MASK_EDGE_POL;
          `GPIN_IDX_P0_MODE:  p0_mode_reg <= wbyte;
          `GPIN_IDX_P1_MODE:  port1_input_mode_reg <= wbyte & `GPIN_MASK_P1_MODE;
          `GPIN_IDX_P2_MODE:  port2_input_mode_pull_sel_reg <= wbyte;
          `GPIN_IDX_IRQ_MASK: irq_mask_reg <= wbyte & `GPIN_MASK_IRQ;
          default:            p0_mode_reg <= p0_mode_reg;
        endcase
      end
      // One wait state: ready rises in the second access cycle
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
      if (psel_in && penable_in && !pready_out && !pwrite_in && addr_ok) begin
        prdata_out <= {24'h000000, rd_byte};
      end else begin
        prdata_out <= 32'h00000000;
      end
    end
  end

  // Pull controls and interrupt output
  always @(posedge clock_in) begin
    if (rst_in) begin
      p0_pull_en_out   <= 8'h00;
      p0_pull_down_out <= 8'h00;
      p1_pull_en_out   <= 8'h00;
      p1_pull_down_out <= 8'h00;
      p2_pull_en_out   <= 5'h00;
      p2_pull_down_out <= 5'h00;
      irq_out          <= 1'b0;
    end else begin
      p0_pull_en_out   <= ~p0_mode_reg;
      p0_pull_down_out <= ~p0_mode_reg
                          & {8{port2_input_mode_pull_sel_reg[`GPIN_BIT_P0_PULL]}};
      p1_pull_en_out   <= ~port1_input_mode_reg & `GPIN_MASK_P1_MODE;
      p1_pull_down_out <= ~port1_input_mode_reg & `GPIN_MASK_P1_MODE
                          & {8{port2_input_mode_pull_sel_reg[`GPIN_BIT_P1_PULL]}};
      p2_pull_en_out   <= ~port2_input_mode_pull_sel_reg[4:0];
      p2_pull_down_out <= ~port2_input_mode_pull_sel_reg[4:0]
                          & {5{port2_input_mode_pull_sel_reg[`GPIN_BIT_P2_PULL]}};
      irq_out          <= |(irq_stat_next & irq_mask_reg);
    end
  end
endmodule // gpin_port_top

// file: verilog/gpin_regs.vh
// Register map, field positions, valid masks and reset value for the port input block
`ifndef GPIN_REGS_VH
`define GPIN_REGS_VH
// Printed offsets are register indexes; byte address is four times the index
`define GPIN_IDX_P0_PEND     8'h89
`define GPIN_IDX_P1_PEND     8'h8A
`define GPIN_IDX_P2_PEND     8'h8B
`define GPIN_IDX_EDGE_POL    8'h8C
`define GPIN_IDX_P0_MODE     8'h8F
`define GPIN_IDX_P1_MODE     8'hF6
`define GPIN_IDX_P2_MODE     8'hF7
`define GPIN_IDX_IRQ_MASK    8'hE0
`define GPIN_IDX_IRQ_STAT    8'hE1
// Field positions
`define GPIN_BIT_P2_PULL     7
`define GPIN_BIT_P1_PULL     6
`define GPIN_BIT_P0_PULL     5
`define GPIN_BIT_P0_EDGE     0
`define GPIN_BIT_P1_EDGE     1
`define GPIN_BIT_P2_EDGE     2
`define GPIN_BIT_USB_RESUME  7
// Valid masks and reset value
`define GPIN_MASK_P1_MODE    8'hFC
`define GPIN_MASK_P2_PEND    8'h1F
`define GPIN_MASK_P0_USB     8'hBF
`define GPIN_MASK_EDGE_POL   8'h07
`define GPIN_MASK_IRQ        8'h07
`define GPIN_RESET_BYTE      8'h00
`endif

// file: verilog/gpin_sync.v
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/1ps
module gpin_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clock_in,
  input  wire             rst_in,
  // Pins in, filtered level out
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] level_reg;
  wire [WIDTH-1:0] level_next;

  // Bits follow only where the second and third stage agree
  assign level_next = (s2_reg & s3_reg) | (level_reg & (s2_reg | s3_reg));
  assign level_out  = level_reg;

  always @(posedge clock_in) begin
    if (rst_in) begin
      s1_reg    <= {WIDTH{1'b0}};
      s2_reg    <= {WIDTH{1'b0}};
      s3_reg    <= {WIDTH{1'b0}};
      level_reg <= {WIDTH{1'b0}};
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end
endmodule // gpin_sync
